// *** rtl/scisc_pkg.sv ***
// Constants, field layouts and state types of the serial status and control block
package scisc_pkg;
	// Register byte addresses on the APB
	localparam logic [11:0] ADDR_STATUS = 12'h000;
	localparam logic [11:0] ADDR_CTRL1  = 12'h004;
	localparam logic [11:0] ADDR_CTRL2  = 12'h008;
	localparam logic [11:0] ADDR_DATA   = 12'h00c;
	localparam logic [11:0] ADDR_BAUD   = 12'h010;
	// Status flag positions
	localparam int ST_TXE  = 7;
	localparam int ST_TXD  = 6;
	localparam int ST_RXF  = 5;
	localparam int ST_IDLE = 4;
	localparam int ST_OVR  = 3;
	localparam int ST_NSE  = 2;
	localparam int ST_FRM  = 1;
	localparam int ST_PAR  = 0;
	// First control register fields
	localparam int C1_RX9  = 7;
	localparam int C1_TX9  = 6;
	localparam int C1_LPD  = 5;
	localparam int C1_LEN9 = 4;
	localparam int C1_WAKE = 3;
	localparam int C1_PON  = 2;
	localparam int C1_PODD = 1;
	localparam int C1_PIE  = 0;
	// Second control register fields
	localparam int C2_TXEIE = 7;
	localparam int C2_TXDIE = 6;
	localparam int C2_RXIE  = 5;
	localparam int C2_IDLIE = 4;
	localparam int C2_TXEN  = 3;
	localparam int C2_RXEN  = 2;
	localparam int C2_MUTE  = 1;
	localparam int C2_BRK   = 0;
	// Reset values and clear masks
	localparam logic [7:0] STATUS_RST = 8'hc0;
	localparam logic [7:0] CTRL_RST   = 8'h00;
	localparam logic [7:0] BAUD_RST   = 8'h00;
	localparam logic [7:0] CLR_TX_MSK = 8'hc0;
	localparam logic [7:0] CLR_RX_MSK = 8'h3f;
	// Oversampling: 16 ticks a bit, votes on ticks 7, 8 and 9
	localparam logic [3:0] OVS_LAST  = 4'hf;
	localparam logic [3:0] SMP_FIRST = 4'h7;
	localparam logic [3:0] SMP_LAST  = 4'h9;
	localparam logic [3:0] LAST_BIT8 = 4'h7;
	localparam logic [3:0] LAST_BIT9 = 4'h8;
	// Idle line: a whole frame of ones, in ticks
	localparam logic [7:0] IDLE_TK8 = 8'ha0;
	localparam logic [7:0] IDLE_TK9 = 8'hb0;

	typedef enum logic [1:0] {
		TX_IDLE  = 2'h0,
		TX_START = 2'h1,
		TX_DATA  = 2'h2,
		TX_STOP  = 2'h3
	} scisc_tx_t;

	typedef enum logic [1:0] {
		RX_IDLE  = 2'h0,
		RX_START = 2'h1,
		RX_DATA  = 2'h2,
		RX_STOP  = 2'h3
	} scisc_rx_t;

	// Processor state seen by the block
	typedef struct packed {
		logic halt;
		logic wait_st;
		logic irq_masked;
	} scisc_cpu_t;

	// Line and processor-facing outputs
	typedef struct packed {
		logic txd;
		logic txd_oe;
		logic irq_req;
		logic wake_req;
	} scisc_out_t;

	typedef struct packed {
		logic [7:0] cnt;
		logic       tick;
	} scisc_tick_st_t;

	typedef struct packed {
		logic [7:0] status;
		logic [7:0] ctrl1;
		logic [7:0] ctrl2;
		logic [7:0] baud;
		logic [7:0] tx_hold;
		logic [7:0] rx_hold;
		logic       armed;
		logic       irq;
		logic       wake;
		scisc_tx_t  tx_st;
		logic [8:0] tx_sh;
		logic [3:0] tx_cnt;
		logic [3:0] tx_idx;
		logic       tx_len9;
		logic       tx_brk;
		logic       txd;
		logic       txd_oe;
		logic       sync0;
		logic       sync1;
		scisc_rx_t  rx_st;
		logic [3:0] rx_cnt;
		logic [3:0] rx_idx;
		logic [8:0] rx_sh;
		logic [2:0] rx_smp;
		logic       rx_noise;
		logic       rx_len9;
		logic       rx_pon;
		logic       rx_podd;
		logic [7:0] idle_cnt;
		logic       idle_armed;
	} scisc_state_t;

	localparam scisc_state_t STATE_RST = '{
		status: STATUS_RST, ctrl1: CTRL_RST, ctrl2: CTRL_RST, baud: BAUD_RST,
		tx_st: TX_IDLE, rx_st: RX_IDLE, txd: 1'h1, sync0: 1'h1, sync1: 1'h1,
		default: '0
	};
endpackage

// *** rtl/scisc_tick.sv ***
// Oversampling tick generator: one tick every baud+1 core clocks
`timescale 1ns/1ps
`default_nettype none
module scisc_tick (
	input  wire logic       core_clk, // Core clock
	input  wire logic       reset_n,  // Async reset, active low
	input  wire logic       run,      // Prescaler running
	input  wire logic [7:0] div,      // Divide value minus one
	output logic            tick      // One-cycle oversample tick
);
	scisc_pkg::scisc_tick_st_t s;
	scisc_pkg::scisc_tick_st_t n;

	// Stopped prescaler holds its count so no power is spent toggling
	always_comb begin
		n = s;
		n.tick = 1'h0;
		if (run) begin
			if (s.cnt >= div) begin
				n.cnt = 8'h00;
				n.tick = 1'h1;
			end else begin
				n.cnt = s.cnt + 8'h01;
			end
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign tick = s.tick;
endmodule // scisc_tick
`default_nettype wire

// *** rtl/scisc_core.sv ***
// Serial interface status flags, control, frame engines, interrupt and low-power logic
//
// Overview of operation
//- Any enabled serial event wakes the processor from wait; operation continues there.
//- Halt freezes all registers and traffic; no serial event ends halt.
//- One shared interrupt, gated by each enable and the global mask.
//- Enables: empty, done, receive covers full and overrun, idle, parity.
//- Empty flag sets on load into shifter; cleared by status then data write.
//- Holding register loads into shifter only while the empty flag is clear.
//- Done flag sets after data frames, never after break; status then write clears.
//- Full flag sets when a word becomes readable; status then data read clears.
//- Idle flag sets on idle line, rearmed only by the next full flag.
//- Overrun sets when a word completes while full; holding register kept.
//- Noise flag on noisy frame, no own interrupt, cleared by status then read.
//- Framing flag on bad stop or break, no own interrupt, same clear.
//- Framing error with overrun sets only overrun.
//- Parity flag on failed check, interrupts with parity enable, same clear.
//- Status resets with empty and done set, the rest clear.
//- Nine-bit frames capture and send the ninth bit fields.
//- Low-power disable stops prescaler and outputs after the current byte.
//- Word length bit picks eight or nine data bits, one start, one stop.
//- Wake method bit: idle line when 0, address mark when 1.
//- Parity replaces the top data bit and is checked; applies from next byte.
//- Parity select: even 0, odd 1; applies from the next byte.
`timescale 1ns/1ps
`default_nettype none
module scisc_core (
	input  wire logic                  core_clk, // 40 MHz core clock
	input  wire logic                  reset_n,  // Async reset, active low
	input  wire logic                  psel,     // APB select
	input  wire logic                  penable,  // APB access phase
	input  wire logic                  pwrite,   // APB write
	input  wire logic [11:0]           paddr,    // APB byte address
	input  wire logic [31:0]           pwdata,   // APB write data
	output logic      [31:0]           prdata,   // APB read data
	output logic                       pready,   // APB ready
	output logic                       pslverr,  // APB error on unmapped address
	input  wire logic                  rxd,      // Receive line pin
	input  wire scisc_pkg::scisc_cpu_t cpu,      // Processor power and mask state
	output scisc_pkg::scisc_out_t      pins      // Line and processor outputs
);
	scisc_pkg::scisc_state_t s;
	scisc_pkg::scisc_state_t n;
	logic       tick;
	logic       run;
	logic       acc;
	logic       hit;
	logic       tx_load;
	logic       rx_deliver;
	logic       ovr_evt;
	logic       clr_tx;
	logic       clr_rx;
	logic [7:0] set;
	logic [8:0] word;
	logic [4:0] evts;
	logic       tx_end;
	logic       rx_end;
	logic       maj;
	logic       noisy;
	logic       frm_err;
	logic       msb;
	logic       addr_ok;
	logic [7:0] idle_thr;

	// Prescaler idles once traffic has drained under low-power disable
	assign run = !cpu.halt && !(s.ctrl1[scisc_pkg::C1_LPD] && s.tx_st == scisc_pkg::TX_IDLE
		&& s.rx_st == scisc_pkg::RX_IDLE);

	scisc_tick u_tick (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.run      (run),
		.div      (s.baud),
		.tick     (tick)
	);

	// Bus decode; every access completes in its first access cycle
	assign acc = psel && penable;
	assign hit = paddr == scisc_pkg::ADDR_STATUS || paddr == scisc_pkg::ADDR_CTRL1 ||
		paddr == scisc_pkg::ADDR_CTRL2 || paddr == scisc_pkg::ADDR_DATA ||
		paddr == scisc_pkg::ADDR_BAUD;
	assign pready = 1'h1;
	assign pslverr = acc && !hit;

	// Read mux straight from the registers
	always_comb begin
		prdata = 32'h0000_0000;
		unique case (paddr)
			scisc_pkg::ADDR_STATUS: prdata = {24'h000000, s.status};
			scisc_pkg::ADDR_CTRL1:  prdata = {24'h000000, s.ctrl1};
			scisc_pkg::ADDR_CTRL2:  prdata = {24'h000000, s.ctrl2};
			scisc_pkg::ADDR_DATA:   prdata = {24'h000000, s.rx_hold};
			scisc_pkg::ADDR_BAUD:   prdata = {24'h000000, s.baud};
			default:                prdata = 32'h0000_0000;
		endcase
	end

	// Word for the shifter; parity takes the top data position
	always_comb begin
		word = {s.ctrl1[scisc_pkg::C1_TX9], s.tx_hold};
		if (s.ctrl1[scisc_pkg::C1_PON]) begin
			if (s.ctrl1[scisc_pkg::C1_LEN9]) begin
				word[8] = (^s.tx_hold) ^ s.ctrl1[scisc_pkg::C1_PODD];
			end else begin
				word[7] = (^s.tx_hold[6:0]) ^ s.ctrl1[scisc_pkg::C1_PODD];
			end
		end
	end

	// Receive vote and frame checks
	assign maj = (s.rx_smp[0] & s.rx_smp[1]) | (s.rx_smp[0] & s.rx_smp[2]) |
		(s.rx_smp[1] & s.rx_smp[2]);
	assign noisy = !(&s.rx_smp) && (|s.rx_smp);
	assign frm_err = !maj;
	assign msb = s.rx_len9 ? s.rx_sh[8] : s.rx_sh[7];
	assign addr_ok = !s.ctrl2[scisc_pkg::C2_MUTE] || (s.ctrl1[scisc_pkg::C1_WAKE] && msb);
	assign idle_thr = s.ctrl1[scisc_pkg::C1_LEN9] ? scisc_pkg::IDLE_TK9 : scisc_pkg::IDLE_TK8;
	assign tx_end = tick && s.tx_cnt == scisc_pkg::OVS_LAST;
	assign rx_end = tick && s.rx_cnt == scisc_pkg::OVS_LAST;
	assign rx_deliver = rx_end && s.rx_st == scisc_pkg::RX_STOP && addr_ok &&
		!s.status[scisc_pkg::ST_RXF];
	assign ovr_evt = rx_end && s.rx_st == scisc_pkg::RX_STOP && addr_ok &&
		s.status[scisc_pkg::ST_RXF];

	// Enabled events; receive enable covers both full and overrun
	assign evts = {
		s.status[scisc_pkg::ST_TXE] & s.ctrl2[scisc_pkg::C2_TXEIE],
		s.status[scisc_pkg::ST_TXD] & s.ctrl2[scisc_pkg::C2_TXDIE],
		(s.status[scisc_pkg::ST_RXF] | s.status[scisc_pkg::ST_OVR]) & s.ctrl2[scisc_pkg::C2_RXIE],
		s.status[scisc_pkg::ST_IDLE] & s.ctrl2[scisc_pkg::C2_IDLIE],
		s.status[scisc_pkg::ST_PAR] & s.ctrl1[scisc_pkg::C1_PIE]
	};

	// Next state of the whole block
	always_comb begin
		n = s;
		clr_tx = 1'h0;
		clr_rx = 1'h0;
		set = 8'h00;
		tx_load = 1'h0;
		n.sync0 = rxd;
		n.sync1 = s.sync0;
		// Register accesses; a status access arms the clear sequence
		if (acc) begin
			unique case (paddr)
				scisc_pkg::ADDR_STATUS: n.armed = 1'h1;
				scisc_pkg::ADDR_CTRL1: begin
					if (pwrite) begin
						n.ctrl1 = {s.ctrl1[scisc_pkg::C1_RX9], pwdata[6:0]};
					end
				end
				scisc_pkg::ADDR_CTRL2: begin
					if (pwrite) begin
						n.ctrl2 = pwdata[7:0];
					end
				end
				scisc_pkg::ADDR_BAUD: begin
					if (pwrite) begin
						n.baud = pwdata[7:0];
					end
				end
				scisc_pkg::ADDR_DATA: begin
					n.armed = 1'h0;
					if (pwrite) begin
						n.tx_hold = pwdata[7:0];
						clr_tx = s.armed;
					end else begin
						clr_rx = s.armed;
					end
				end
				default: n.armed = s.armed;
			endcase
		end
		// Transmit engine; frame format is fixed when the word is loaded
		if (s.tx_st != scisc_pkg::TX_IDLE && tick) begin
			n.tx_cnt = s.tx_cnt + 4'h1;
		end
		unique case (s.tx_st)
			scisc_pkg::TX_IDLE: begin
				n.txd = 1'h1;
				if (s.ctrl2[scisc_pkg::C2_TXEN] && !s.ctrl1[scisc_pkg::C1_LPD]) begin
					n.tx_cnt = 4'h0;
					n.tx_len9 = s.ctrl1[scisc_pkg::C1_LEN9];
					if (s.ctrl2[scisc_pkg::C2_BRK]) begin
						n.tx_sh = 9'h000;
						n.tx_brk = 1'h1;
						n.txd = 1'h0;
						n.tx_st = scisc_pkg::TX_START;
					end else if (!s.status[scisc_pkg::ST_TXE]) begin
						tx_load = 1'h1;
						set[scisc_pkg::ST_TXE] = 1'h1;
						n.tx_sh = word;
						n.tx_brk = 1'h0;
						n.txd = 1'h0;
						n.tx_st = scisc_pkg::TX_START;
					end
				end
			end
			scisc_pkg::TX_START: begin
				if (tx_end) begin
					n.txd = s.tx_sh[0];
					n.tx_sh = s.tx_sh >> 1;
					n.tx_idx = 4'h0;
					n.tx_st = scisc_pkg::TX_DATA;
				end
			end
			scisc_pkg::TX_DATA: begin
				if (tx_end) begin
					if (s.tx_idx == (s.tx_len9 ? scisc_pkg::LAST_BIT9 : scisc_pkg::LAST_BIT8)) begin
						n.txd = !s.tx_brk;
						n.tx_st = scisc_pkg::TX_STOP;
					end else begin
						n.tx_idx = s.tx_idx + 4'h1;
						n.txd = s.tx_sh[0];
						n.tx_sh = s.tx_sh >> 1;
					end
				end
			end
			scisc_pkg::TX_STOP: begin
				if (tx_end) begin
					n.txd = 1'h1;
					n.tx_st = scisc_pkg::TX_IDLE;
					set[scisc_pkg::ST_TXD] = !s.tx_brk;
				end
			end
		endcase
		// Receive engine: vote on ticks 7 to 9 of each bit
		if (tick && s.rx_st != scisc_pkg::RX_IDLE) begin
			n.rx_cnt = s.rx_cnt + 4'h1;
			if (s.rx_cnt >= scisc_pkg::SMP_FIRST && s.rx_cnt <= scisc_pkg::SMP_LAST) begin
				n.rx_smp = {s.rx_smp[1:0], s.sync1};
			end
		end
		unique case (s.rx_st)
			scisc_pkg::RX_IDLE: begin
				if (tick && s.ctrl2[scisc_pkg::C2_RXEN]) begin
					if (!s.sync1 && !s.ctrl1[scisc_pkg::C1_LPD]) begin
						n.rx_st = scisc_pkg::RX_START;
						n.rx_cnt = 4'h0;
						n.idle_cnt = 8'h00;
						n.rx_noise = 1'h0;
						n.rx_len9 = s.ctrl1[scisc_pkg::C1_LEN9];
						n.rx_pon = s.ctrl1[scisc_pkg::C1_PON];
						n.rx_podd = s.ctrl1[scisc_pkg::C1_PODD];
					end else if (!s.sync1) begin
						n.idle_cnt = 8'h00;
					end else if (s.idle_cnt < idle_thr) begin
						n.idle_cnt = s.idle_cnt + 8'h01;
						if (s.idle_cnt == idle_thr - 8'h01) begin
							if (s.ctrl2[scisc_pkg::C2_MUTE]) begin
								n.ctrl2[scisc_pkg::C2_MUTE] = s.ctrl1[scisc_pkg::C1_WAKE];
							end else if (s.idle_armed) begin
								set[scisc_pkg::ST_IDLE] = 1'h1;
								n.idle_armed = 1'h0;
							end
						end
					end
				end
			end
			scisc_pkg::RX_START: begin
				if (rx_end) begin
					n.rx_noise = noisy;
					n.rx_idx = 4'h0;
					n.rx_st = maj ? scisc_pkg::RX_IDLE : scisc_pkg::RX_DATA;
				end
			end
			scisc_pkg::RX_DATA: begin
				if (rx_end) begin
					n.rx_sh[s.rx_idx] = maj;
					n.rx_noise = s.rx_noise | noisy;
					if (s.rx_idx == (s.rx_len9 ? scisc_pkg::LAST_BIT9 : scisc_pkg::LAST_BIT8)) begin
						n.rx_st = scisc_pkg::RX_STOP;
					end else begin
						n.rx_idx = s.rx_idx + 4'h1;
					end
				end
			end
			scisc_pkg::RX_STOP: begin
				if (rx_end) begin
					n.rx_st = scisc_pkg::RX_IDLE;
					n.idle_cnt = 8'h00;
					if (addr_ok) begin
						n.ctrl2[scisc_pkg::C2_MUTE] = 1'h0;
					end
					// Overrun keeps the held word and hides the framing error
					set[scisc_pkg::ST_OVR] = ovr_evt;
					if (rx_deliver) begin
						n.rx_hold = s.rx_sh[7:0];
						if (s.rx_len9) begin
							n.ctrl1[scisc_pkg::C1_RX9] = s.rx_sh[8];
						end
						set[scisc_pkg::ST_RXF] = 1'h1;
						set[scisc_pkg::ST_NSE] = s.rx_noise | noisy;
						set[scisc_pkg::ST_FRM] = frm_err;
						set[scisc_pkg::ST_PAR] = s.rx_pon && ((s.rx_len9 ? ^s.rx_sh :
							^s.rx_sh[7:0]) ^ s.rx_podd);
						n.idle_armed = 1'h1;
					end
				end
			end
		endcase
		// A flag set in the clearing cycle survives the clear
		n.status = (s.status & ~((clr_tx ? scisc_pkg::CLR_TX_MSK : 8'h00) |
			(clr_rx ? scisc_pkg::CLR_RX_MSK : 8'h00))) | set;
		n.txd_oe = s.ctrl2[scisc_pkg::C2_TXEN] && !(s.ctrl1[scisc_pkg::C1_LPD] &&
			s.tx_st == scisc_pkg::TX_IDLE);
		n.irq = (|evts) && !cpu.irq_masked;
		n.wake = (|evts) && cpu.wait_st;
		// Halt freezes everything and must never wake the processor
		if (cpu.halt) begin
			n = s;
			n.wake = 1'h0;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			s <= scisc_pkg::STATE_RST;
		end else begin
			s <= n;
		end
	end

	assign pins = '{txd: s.txd, txd_oe: s.txd_oe, irq_req: s.irq, wake_req: s.wake};

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	txe_guard_a: assert property (s.tx_st == scisc_pkg::TX_START && !s.tx_brk &&
		$past(s.tx_st) == scisc_pkg::TX_IDLE |-> !$past(s.status[scisc_pkg::ST_TXE]))
		else $error("shifter loaded while empty flag set");
	txe_set_a: assert property (tx_load && !cpu.halt |=> s.status[scisc_pkg::ST_TXE])
		else $error("empty flag not set on load");
	tx_done_a: assert property ($rose(s.status[scisc_pkg::ST_TXD]) |->
		$past(s.tx_st) == scisc_pkg::TX_STOP && !$past(s.tx_brk))
		else $error("done flag without data frame end");
	ovr_keep_a: assert property (ovr_evt && !cpu.halt |=> s.status[scisc_pkg::ST_OVR] &&
		$stable(s.rx_hold) && !$rose(s.status[scisc_pkg::ST_FRM]))
		else $error("overrun handling wrong");
	rxf_set_a: assert property (rx_deliver && !cpu.halt |=> s.status[scisc_pkg::ST_RXF] &&
		s.rx_hold == $past(s.rx_sh[7:0]))
		else $error("received word not delivered");
	idle_once_a: assert property ($rose(s.status[scisc_pkg::ST_IDLE]) |->
		$past(s.idle_armed))
		else $error("idle flag set while not rearmed");
	halt_freeze_a: assert property (cpu.halt && $past(cpu.halt) |->
		$stable(s.status) && $stable(s.txd) && !pins.wake_req)
		else $error("state moved during halt");
	irq_gate_a: assert property (cpu.irq_masked && !cpu.halt |=> !pins.irq_req)
		else $error("interrupt raised while masked");
	wait_wake_a: assert property (pins.wake_req |-> $past(cpu.wait_st) && $past(|evts))
		else $error("wake without enabled event in wait");
	lpd_quiet_a: assert property (s.ctrl1[scisc_pkg::C1_LPD] && s.tx_st == scisc_pkg::TX_IDLE
		|=> s.tx_st == scisc_pkg::TX_IDLE)
		else $error("frame started under low-power disable");
endmodule // scisc_core
`default_nettype wire

// *** verification/scisc_remote.sv ***
// Far-end serial partner: drives the receive line and decodes the transmit line
`timescale 1ns/1ps
`default_nettype none
module scisc_remote #(
	parameter int BIT_CLKS = 16 // Clocks a bit with the baud register at zero
) (
	input  wire logic core_clk, // Core clock
	input  wire logic txd,      // Block transmit line
	input  wire logic glitch,   // Spike the middle vote of the first data bit
	output logic      rxd       // Block receive line, pulled high when idle
);
	// Line rests at its pull-up level outside frames
	initial rxd = 1'b1;

	// Start bit, n data bits LSB first, chosen stop level, then an idle tail
	task automatic send(input logic [8:0] w, input int n, input logic stop);
		@(posedge core_clk);
		rxd <= 1'b0;
		repeat (BIT_CLKS) @(posedge core_clk);
		for (int i = 0; i < n; i++) begin
			rxd <= w[i];
			if (glitch && i == 0) begin
				// One-clock spike that only the middle vote sees
				repeat (BIT_CLKS / 2 + 1) @(posedge core_clk);
				rxd <= !w[i];
				@(posedge core_clk);
				rxd <= w[i];
				repeat (BIT_CLKS / 2 - 2) @(posedge core_clk);
			end else begin
				repeat (BIT_CLKS) @(posedge core_clk);
			end
		end
		rxd <= stop;
		repeat (BIT_CLKS) @(posedge core_clk);
		rxd <= 1'b1;
		// Tail stays well short of an idle-line frame
		repeat (20) @(posedge core_clk);
	endtask

	// Samples mid-bit; a silent transmitter is caught by the bench timeout
	task automatic catch(output logic [8:0] w, input int n);
		w = 9'h000;
		do @(posedge core_clk); while (txd !== 1'b0);
		repeat (BIT_CLKS / 2) @(posedge core_clk);
		for (int i = 0; i < n; i++) begin
			repeat (BIT_CLKS) @(posedge core_clk);
			w[i] = txd;
		end
		// Past the stop bit, so the done flag has landed before the next bus read
		repeat (BIT_CLKS + 8) @(posedge core_clk);
	endtask
endmodule // scisc_remote
`default_nettype wire

// *** verification/testbench.sv ***
// Self-checking bench for the serial status and control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam logic [11:0] A_ST = scisc_pkg::ADDR_STATUS;
	localparam logic [11:0] A_C1 = scisc_pkg::ADDR_CTRL1;
	localparam logic [11:0] A_C2 = scisc_pkg::ADDR_CTRL2;
	localparam logic [11:0] A_DT = scisc_pkg::ADDR_DATA;
	logic                  core_clk;
	logic                  reset_n;
	logic                  psel;
	logic                  penable;
	logic                  pwrite;
	logic [11:0]           paddr;
	logic [31:0]           pwdata;
	logic [31:0]           prdata;
	logic                  pready;
	logic                  pslverr;
	logic                  rxd;
	logic                  glitch;
	scisc_pkg::scisc_cpu_t cpu;
	scisc_pkg::scisc_out_t pins;
	logic [31:0]           r;
	logic                  e;
	logic [8:0]            w;
	int                    bad_count;
	int                    checks;
	int                    cyc;

	scisc_core scisc_core_inst (
		.core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rxd(rxd), .cpu(cpu), .pins(pins)
	);
	scisc_remote scisc_remote_inst (
		.core_clk(core_clk), .txd(pins.txd), .glitch(glitch), .rxd(rxd)
	);

	// 40 MHz core clock
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	task automatic end_of_test();
		if (bad_count == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Hang guard: the whole sequence needs well under this many cycles
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			end_of_test();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// APB transfer; pready is never assumed, only the bench timeout ends the wait
	task automatic apb(input logic wr_en, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= wr_en;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a);
		apb(1'b0, a, 32'h0);
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d});
	endtask

	task automatic t_reset();
		rd(A_ST);
		chk(r, 32'hc0);
		rd(A_C1);
		chk(r, 32'h0);
		rd(12'h020);
		chk({31'h0, e}, 32'h1);
	endtask

	// Unarmed data write must leave the frame unsent
	task automatic t_tx();
		wr(A_C2, 8'h08);
		rd(A_DT);
		wr(A_DT, 8'h5a);
		repeat (40) @(posedge core_clk);
		chk({31'h0, pins.txd}, 32'h1);
		rd(A_ST);
		fork
			scisc_remote_inst.catch(w, 8);
			begin
				wr(A_DT, 8'h96);
				rd(A_ST);
				chk(r, 32'h80);
			end
		join
		chk({23'h0, w}, 32'h96);
		rd(A_ST);
		chk(r, 32'hc0);
	endtask

	task automatic t_irq();
		logic [7:0] ie [3] = '{8'h88, 8'h48, 8'h28};
		logic       ex [3] = '{1'b1, 1'b1, 1'b0};
		for (int i = 0; i < 3; i++) begin
			wr(A_C2, ie[i]);
			repeat (3) @(posedge core_clk);
			chk({31'h0, pins.irq_req}, {31'h0, ex[i]});
		end
		wr(A_C2, 8'h48);
		cpu <= '{halt: 1'b0, wait_st: 1'b1, irq_masked: 1'b1};
		repeat (3) @(posedge core_clk);
		chk({31'h0, pins.irq_req}, 32'h0);
		chk({31'h0, pins.wake_req}, 32'h1);
		cpu <= '0;
		wr(A_C2, 8'h08);
	endtask

	// Idle bit masked where the idle timer may already have run out
	task automatic t_rx();
		wr(A_C2, 8'h2c);
		scisc_remote_inst.send(9'h03c, 8, 1'b1);
		rd(A_ST);
		chk(r & 32'hef, 32'he0);
		chk({31'h0, pins.irq_req}, 32'h1);
		rd(A_DT);
		chk(r, 32'h3c);
		repeat (200) @(posedge core_clk);
		rd(A_ST);
		chk(r, 32'hd0);
		rd(A_DT);
		repeat (200) @(posedge core_clk);
		rd(A_ST);
		chk(r, 32'hc0);
		scisc_remote_inst.send(9'h011, 8, 1'b1);
		scisc_remote_inst.send(9'h022, 8, 1'b0);
		rd(A_ST);
		chk(r & 32'hef, 32'he8);
		rd(A_DT);
		chk(r, 32'h11);
		scisc_remote_inst.send(9'h033, 8, 1'b0);
		rd(A_ST);
		chk(r & 32'hef, 32'he2);
		rd(A_DT);
	endtask

	task automatic t_par();
		logic [7:0] cfg [4] = '{8'h05, 8'h05, 8'h06, 8'h06};
		logic [8:0] wd  [4] = '{9'h083, 9'h003, 9'h003, 9'h083};
		logic [7:0] ex  [4] = '{8'he1, 8'he0, 8'he1, 8'he0};
		logic       iq  [4] = '{1'b1, 1'b0, 1'b0, 1'b0};
		// Receive interrupt off, so only the parity enable can raise the request
		wr(A_C2, 8'h0c);
		for (int i = 0; i < 4; i++) begin
			wr(A_C1, cfg[i]);
			scisc_remote_inst.send(wd[i], 8, 1'b1);
			rd(A_ST);
			chk(r & 32'hef, {24'h0, ex[i]});
			chk({31'h0, pins.irq_req}, {31'h0, iq[i]});
			rd(A_DT);
		end
		wr(A_C1, 8'h04);
		rd(A_ST);
		fork
			scisc_remote_inst.catch(w, 8);
			wr(A_DT, 8'h83);
		join
		chk({23'h0, w}, 32'h03);
		wr(A_C1, 8'h00);
		// Noisy first data bit: majority keeps the value, noise flag raises no request
		glitch <= 1'b1;
		scisc_remote_inst.send(9'h044, 8, 1'b1);
		glitch <= 1'b0;
		rd(A_ST);
		chk(r & 32'hef, 32'he4);
		chk({31'h0, pins.irq_req}, 32'h0);
		rd(A_DT);
		chk(r, 32'h44);
		wr(A_C2, 8'h2c);
	endtask

	// Nine-bit frames: ninth bit captured on receive and sent on transmit
	task automatic t_nine();
		wr(A_C1, 8'h50);
		scisc_remote_inst.send(9'h1a5, 9, 1'b1);
		rd(A_ST);
		rd(A_DT);
		chk(r, 32'ha5);
		rd(A_C1);
		chk(r, 32'hd0);
		fork
			scisc_remote_inst.catch(w, 9);
			begin
				rd(A_ST);
				wr(A_DT, 8'h5a);
			end
		join
		chk({23'h0, w}, 32'h15a);
		wr(A_C1, 8'h00);
	endtask

	// Break frames hold the line low, keep a written word waiting, set no done flag
	task automatic t_break();
		wr(A_C2, 8'h2d);
		repeat (40) @(posedge core_clk);
		chk({31'h0, pins.txd}, 32'h0);
		rd(A_ST);
		wr(A_DT, 8'h55);
		repeat (400) @(posedge core_clk);
		rd(A_ST);
		chk(r & 32'hc0, 32'h00);
		wr(A_C2, 8'h2c);
		repeat (400) @(posedge core_clk);
		rd(A_ST);
		chk(r & 32'hc0, 32'hc0);
	endtask

	// Muted receiver with address-mark wake drops plain words, takes marked ones
	task automatic t_wake();
		wr(A_C1, 8'h08);
		wr(A_C2, 8'h0e);
		scisc_remote_inst.send(9'h011, 8, 1'b1);
		rd(A_ST);
		chk(r & 32'h28, 32'h00);
		scisc_remote_inst.send(9'h091, 8, 1'b1);
		rd(A_ST);
		chk(r & 32'h20, 32'h20);
		rd(A_DT);
		chk(r, 32'h91);
		rd(A_C2);
		chk(r, 32'h0c);
		wr(A_C1, 8'h00);
		wr(A_C2, 8'h2c);
	endtask

	task automatic t_power();
		cpu.halt <= 1'b1;
		wr(A_C2, 8'h00);
		cpu.halt <= 1'b0;
		rd(A_C2);
		chk(r, 32'h2c);
		wr(A_C1, 8'h20);
		repeat (4) @(posedge core_clk);
		chk({31'h0, pins.txd_oe}, 32'h0);
		wr(A_C1, 8'h00);
		repeat (4) @(posedge core_clk);
		chk({31'h0, pins.txd_oe}, 32'h1);
	endtask

	// Reset for 10 cycles, then the scenarios in order
	initial begin
		reset_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		cpu = '0;
		glitch = 1'b0;
		bad_count = 0;
		checks = 0;
		cyc = 0;
		repeat (10) @(posedge core_clk);
		reset_n <= 1'b1;
		t_reset();
		t_tx();
		t_irq();
		t_rx();
		t_par();
		t_nine();
		t_break();
		t_wake();
		t_power();
		end_of_test();
	end
endmodule // testbench
`default_nettype wire
